// ===== mfi_decoder.sv
// Purpose: decode five debounced multifunction terminals into drive commands
// Assumes: configuration inputs held stable while running
// Notes:   ramp engine and parameter store live outside; this block selects
`timescale 1ns/1ps
module mfi_decoder
   import mfi_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYC  // cycles per scan tick, 1 ms default
) (
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire logic                 input_terminal_1,
   input  wire logic                 input_terminal_2,
   input  wire logic                 input_terminal_3,
   input  wire logic                 input_terminal_4,
   input  wire logic                 input_terminal_5,
   input  wire logic [4:0]           term_fn_1,
   input  wire logic [4:0]           term_fn_2,
   input  wire logic [4:0]           term_fn_3,
   input  wire logic [4:0]           term_fn_4,
   input  wire logic [4:0]           term_fn_5,
   input  wire logic [4:0]           polarity_nc,
   input  wire logic [7:0]           scan_ms,
   input  wire logic [1:0]           run_mode,
   input  wire logic [1:0]           keep_mode,
   input  wire logic [FREQ_W-1:0]    ud_step,
   input  wire logic [FREQ_W-1:0]    freq_upper,
   input  wire logic [FREQ_W-1:0]    out_freq,
   output logic [4:0]                term_state,
   output logic                      run_fwd,
   output logic                      run_rev,
   output logic [2:0]                speed_idx,
   output logic                      jog_fwd,
   output logic                      jog_rev,
   output logic                      ramp_set2,
   output logic                      ramp_hold,
   output logic                      run_src_alt,
   output logic                      freq_src_alt,
   output logic                      rapid_stop,
   output logic                      base_block,
   output logic                      pid_disable,
   output logic                      fault_reset,
   output logic                      auto_seq_en,
   output logic                      ud_enable,
   output logic [FREQ_W-1:0]         ud_freq,
   output logic                      keypad_store,
   output logic [FREQ_W-1:0]         keypad_freq
);
   import mfi_pkg::*;

   logic [4:0]        raw;
   logic [4:0]        pol_in;
   logic [16:0]       tick_cnt_r;
   logic              tick;
   logic [4:0]        state_r;
   logic [4:0]        rst_pulse_r;
   logic              three_wire;
   logic [4:0]        fn   [NUM_TERM];
   logic [4:0]        usable;
   logic              run_r;
   logic              run_cmd;
   logic              fwd_cmd;
   logic              rev_cmd;
   logic              up_on;
   logic              dn_on;
   logic              rst_on;
   mfi_ud_type        ud_r;
   logic [11:0]       hold_r;
   logic              step_now;
   logic [FREQ_W:0]   up_sum;
   logic [FREQ_W-1:0] up_val;
   logic [FREQ_W-1:0] dn_val;
   logic              run_fall;
   logic [4:0]        fn_act [19];

   assign raw = {input_terminal_5, input_terminal_4, input_terminal_3,
                 input_terminal_2, input_terminal_1};
   assign fn[0] = term_fn_1;
   assign fn[1] = term_fn_2;
   assign fn[2] = term_fn_3;
   assign fn[3] = term_fn_4;
   assign fn[4] = term_fn_5;

   assign pol_in = raw ^ polarity_nc;

   assign tick = (tick_cnt_r == 17'(TICK_LEN - 1));
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) tick_cnt_r <= '0;
      else         tick_cnt_r <= tick ? '0 : tick_cnt_r + 17'h00001;
   end

   // per-terminal scan filter
   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g++) begin : g_flt
         logic [7:0] cnt_r;
         logic [7:0] lim;
         assign lim = (scan_ms == 8'h00) ? 8'h01 : scan_ms;
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_r      <= 8'h00;
               state_r[g] <= 1'b0;
            end else if (tick) begin
               if (pol_in[g] == state_r[g]) cnt_r <= 8'h00;
               else if (cnt_r + 8'h01 >= lim) begin
                  cnt_r      <= 8'h00;
                  state_r[g] <= pol_in[g];
               end else cnt_r <= cnt_r + 8'h01;
            end
         end
      end
   endgenerate
   assign term_state = state_r;

   assign three_wire = (run_mode == RUNMODE_3W);
   assign usable     = three_wire ? (state_r & 5'h18) : state_r;

   // function-active matrix, one row per function code
   generate
      for (g = 0; g < 19; g++) begin : g_fn
         genvar t;
         for (t = 0; t < NUM_TERM; t++) begin : g_t
            assign fn_act[g][t] = usable[t] && (fn[t] == 5'(g));
         end
      end
   endgenerate

   // three-wire run latch: t1 run push, t2 stop push (nc), t3 direction
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)                   run_r <= 1'b0;
      else if (!three_wire)          run_r <= 1'b0;
      else if (!state_r[1])          run_r <= 1'b0;
      else if (state_r[0])           run_r <= 1'b1;
   end

   assign fwd_cmd = |fn_act[FN_FWD];
   assign rev_cmd = |fn_act[FN_REV];
   assign run_fwd = three_wire ? (run_r & ~state_r[2])
                               : (fwd_cmd & ~rev_cmd);
   assign run_rev = three_wire ? (run_r & state_r[2])
                               : (rev_cmd & ~fwd_cmd);
   assign run_cmd = run_fwd | run_rev;

   // index steers setpoint and ramp pair downstream
   assign speed_idx = {|fn_act[FN_SPD_MSB], |fn_act[FN_SPD_MID],
                       |fn_act[FN_SPD_LSB]};
   assign jog_fwd = |fn_act[FN_JOG_FWD] & ~|fn_act[FN_JOG_REV];
   assign jog_rev = |fn_act[FN_JOG_REV] & ~|fn_act[FN_JOG_FWD];
   assign ramp_set2    = |fn_act[FN_RAMP2];
   assign ramp_hold    = |fn_act[FN_HOLD];
   assign run_src_alt  = |fn_act[FN_RUN_SRC];
   assign freq_src_alt = |fn_act[FN_FREQ_SRC];
   assign rapid_stop   = |fn_act[FN_RSTOP];
   assign base_block   = |fn_act[FN_BBLOCK];
   assign pid_disable  = |fn_act[FN_PID_OFF];
   assign auto_seq_en  = |fn_act[FN_AUTO];
   assign rst_on       = |fn_act[FN_FRESET];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) rst_pulse_r <= 5'h00;
      else         rst_pulse_r <= {rst_pulse_r[3:0], rst_on};
   end
   assign fault_reset = rst_pulse_r[0] & ~rst_pulse_r[1];

   // up/down stepping: one step per press, repeat per ms after 2 s
   assign up_on    = |fn_act[FN_UP] & ~|fn_act[FN_DOWN] & ud_enable;
   assign dn_on    = |fn_act[FN_DOWN] & ~|fn_act[FN_UP] & ud_enable;
   assign up_sum   = {1'b0, ud_freq} + {1'b0, ud_step};
   assign up_val   = (up_sum > {1'b0, freq_upper}) ? freq_upper
                                                    : up_sum[FREQ_W-1:0];
   assign dn_val   = (ud_freq > ud_step) ? ud_freq - ud_step : '0;
   assign step_now = (ud_r == UD_STEP) || (ud_r == UD_RPT && tick);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ud_r   <= UD_IDLE;
         hold_r <= '0;
      end else begin
         case (ud_r)
            UD_IDLE: if (up_on | dn_on) ud_r <= UD_STEP;
            UD_STEP: begin
               hold_r <= '0;
               ud_r   <= UD_WAIT;
            end
            UD_WAIT:
               if (!(up_on | dn_on)) ud_r <= UD_IDLE;
               else if (tick) begin
                  if (hold_r == 12'(HOLD_MS - 1)) ud_r <= UD_RPT;
                  else hold_r <= hold_r + 12'h001;
               end
            UD_RPT:  if (!(up_on | dn_on)) ud_r <= UD_IDLE;
            default: ud_r <= UD_IDLE;
         endcase
      end
   end

   // previous run for stop detection
   logic run_d_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) run_d_r <= 1'b0;
      else         run_d_r <= run_cmd;
   end
   assign run_fall = run_d_r & ~run_cmd;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ud_freq   <= FREQ_RST;
         ud_enable <= 1'b1;
      end else if (run_fall) begin
         ud_freq   <= (keep_mode == KEEP_ZERO) ? FREQ_RST : ud_freq;
         ud_enable <= (keep_mode != KEEP_HOLD_OFF);
      end else begin
         if (run_cmd) ud_enable <= 1'b1;
         if (step_now && up_on)      ud_freq <= up_val;
         else if (step_now && dn_on) ud_freq <= dn_val;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         keypad_store <= 1'b0;
         keypad_freq  <= FREQ_RST;
      end else begin
         keypad_store <= run_fall && (keep_mode != KEEP_ZERO);
         if (run_fall && keep_mode != KEEP_ZERO) keypad_freq <= out_freq;
      end
   end

   AST_JOG_CONFLICT: assert property (@(posedge core_clk) disable iff
      (!arst_n) !(jog_fwd && jog_rev))
      else $error("both jog outputs active");
   AST_UP_CAP: assert property (@(posedge core_clk) disable iff
      (!arst_n) (step_now && up_on) |=> ud_freq <= freq_upper)
      else $error("up step exceeded upper limit");
   AST_ZERO_KEEP: assert property (@(posedge core_clk) disable iff
      (!arst_n) (run_fall && keep_mode == KEEP_ZERO) |=>
      ud_freq == FREQ_RST)
      else $error("retention mode 1 did not clear");
   AST_KEYPAD: assert property (@(posedge core_clk) disable iff
      (!arst_n) (run_fall && keep_mode != KEEP_ZERO) |=>
      keypad_store && keypad_freq == $past(out_freq))
      else $error("keypad store missing");
   AST_RESET_PULSE: assert property (@(posedge core_clk) disable iff
      (!arst_n) fault_reset |=> !fault_reset)
      else $error("fault reset longer than one cycle");
   AST_TWO_WIRE: assert property (@(posedge core_clk) disable iff
      (!arst_n) (!three_wire && fwd_cmd && rev_cmd) |-> !run_cmd)
      else $error("two-wire conflict did not stop");
   AST_FILTER: assert property (@(posedge core_clk) disable iff
      (!arst_n) $changed(state_r) |-> $past(tick))
      else $error("terminal state changed off tick");
   AST_THREE_WIRE: assert property (@(posedge core_clk) disable iff
      (!arst_n) three_wire |-> usable[2:0] == 3'h0)
      else $error("three-wire terminals leaked into functions");

   // press accepted from idle, then exactly one step state
   sequence s_ud_press;
      (ud_r == UD_IDLE) && (up_on || dn_on);
   endsequence
   sequence s_ud_once;
      (ud_r == UD_STEP) ##1 (ud_r != UD_STEP);
   endsequence
   AST_ONE_STEP: assert property (@(posedge core_clk) disable iff
      (!arst_n) s_ud_press |=> s_ud_once)
      else $error("press did not give a single step");
   // down never raises the command
   AST_DOWN_FLOOR: assert property (@(posedge core_clk) disable iff
      (!arst_n) (step_now && dn_on) |=> ud_freq <= $past(ud_freq))
      else $error("down step raised the command");
   // running re-enables up/down
   AST_RUN_ENABLE: assert property (@(posedge core_clk) disable iff
      (!arst_n) run_cmd |=> ud_enable)
      else $error("up/down not enabled while running");
   // filtered state only moves on a tick
   AST_FILTER_HOLD: assert property (@(posedge core_clk) disable iff
      (!arst_n) !tick |=> $stable(state_r))
      else $error("terminal state moved between ticks");
   // pressed stop push (state_r[1] low) ends three-wire run
   AST_THREE_STOP: assert property (@(posedge core_clk) disable iff
      (!arst_n) (three_wire && !state_r[1]) |=>
      (!run_fwd && !run_rev) || !three_wire)
      else $error("three-wire stop did not stop");
   // scan tick is a single-cycle strobe
   AST_TICK_PULSE: assert property (@(posedge core_clk) disable iff
      (!arst_n) tick |=> !tick)
      else $error("scan tick longer than one cycle");
   // activation of reset function yields a pulse
   AST_RESET_RISE: assert property (@(posedge core_clk) disable iff
      (!arst_n) $rose(rst_on) |=> fault_reset)
      else $error("fault reset pulse missing");
endmodule : mfi_decoder

// ===== mfi_decoder_test.sv
// Purpose: self-checking bench for the multifunction input decoder
// Assumes: scan tick shortened to SIM_TICK cycles to keep the run short
// Notes:   decode is checked by changing function codes between ticks
`timescale 1ns/1ps
module mfi_decoder_test;
   import mfi_pkg::*;
   logic              core_clk, arst_n;
   logic [4:0]        want, pins, term_state, polarity_nc;
   logic [4:0]        fn [5];
   logic [7:0]        scan_ms;
   logic [1:0]        run_mode, keep_mode;
   logic [FREQ_W-1:0] ud_step, freq_upper, out_freq, ud_freq, keypad_freq;
   logic              run_fwd, run_rev, jog_fwd, jog_rev, ramp_set2;
   logic              ramp_hold, run_src_alt, freq_src_alt, rapid_stop;
   logic              base_block, pid_disable, fault_reset, auto_seq_en;
   logic              ud_enable, keypad_store, saw_store, saw_reset;
   logic [2:0]        speed_idx;
   logic [9:0]        dec;
   logic [4:0]        codes [10] = '{FN_JOG_FWD, FN_JOG_REV, FN_RAMP2,
      FN_HOLD, FN_RUN_SRC, FN_FREQ_SRC, FN_RSTOP, FN_BBLOCK, FN_PID_OFF,
      FN_AUTO};
   localparam int     SIM_TICK = 100;
   int                err_count = 0;
   int                n_compared = 0;

   // one-hot view of the level commands, in table order
   assign dec = {jog_fwd, jog_rev, ramp_set2, ramp_hold, run_src_alt,
                 freq_src_alt, rapid_stop, base_block, pid_disable,
                 auto_seq_en};

   mfi_switch_model i_sw (.core_clk(core_clk), .want(want), .pins(pins));

   mfi_decoder #(.TICK_LEN(SIM_TICK)) i_dut (
      .core_clk(core_clk), .arst_n(arst_n),
      .input_terminal_1(pins[0]), .input_terminal_2(pins[1]),
      .input_terminal_3(pins[2]), .input_terminal_4(pins[3]),
      .input_terminal_5(pins[4]),
      .term_fn_1(fn[0]), .term_fn_2(fn[1]), .term_fn_3(fn[2]),
      .term_fn_4(fn[3]), .term_fn_5(fn[4]),
      .polarity_nc(polarity_nc), .scan_ms(scan_ms), .run_mode(run_mode),
      .keep_mode(keep_mode), .ud_step(ud_step), .freq_upper(freq_upper),
      .out_freq(out_freq), .term_state(term_state), .run_fwd(run_fwd),
      .run_rev(run_rev), .speed_idx(speed_idx), .jog_fwd(jog_fwd),
      .jog_rev(jog_rev), .ramp_set2(ramp_set2), .ramp_hold(ramp_hold),
      .run_src_alt(run_src_alt), .freq_src_alt(freq_src_alt),
      .rapid_stop(rapid_stop), .base_block(base_block),
      .pid_disable(pid_disable), .fault_reset(fault_reset),
      .auto_seq_en(auto_seq_en), .ud_enable(ud_enable), .ud_freq(ud_freq),
      .keypad_store(keypad_store), .keypad_freq(keypad_freq));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // catch one-cycle pulses while a check window is open
   always @(posedge core_clk) begin
      if (keypad_store === 1'b1) saw_store <= 1'b1;
      if (fault_reset === 1'b1) saw_reset <= 1'b1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // wait bounded for the filtered state, then let outputs land
   task automatic settle(input logic [4:0] exp);
      int n;
      n = 0;
      saw_store = 1'b0;
      while (term_state !== exp && n < 3 * SIM_TICK) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(16'(term_state), 16'(exp));
      if (n >= 3 * SIM_TICK) stop_test();
      repeat (4) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic press(input logic [4:0] w);
      @(posedge core_clk);
      want <= w;
      settle(w ^ polarity_nc);
   endtask : press

   task automatic setfn(input int k, input logic [4:0] c);
      @(posedge core_clk);
      fn[k] <= c;
      @(posedge core_clk);
      #1;
   endtask : setfn

   // main sequence
   initial begin
      arst_n = 1'b0;
      want = 5'h00;
      polarity_nc = 5'h00;
      fn = '{FN_FWD, FN_UP, FN_DOWN, FN_DOWN, 5'h05};
      scan_ms = 8'h02;
      run_mode = 2'h0;
      keep_mode = KEEP_HOLD_OFF;
      ud_step = 16'h0064;
      freq_upper = 16'h0050;
      out_freq = 16'h1234;
      saw_store = 1'b0;
      saw_reset = 1'b0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(16'({ud_enable, term_state}), 16'h0020);
      i_sw.glitch(4, SIM_TICK / 2);
      repeat (4 * SIM_TICK) @(posedge core_clk);
      #1;
      chk(16'(term_state), 16'h0000);
      scan_ms <= 8'h01;
      $display("test filter done");
      press(5'h03);
      chk(16'(run_fwd), 16'h0001);
      chk(ud_freq, freq_upper);
      press(5'h04);
      chk(16'(saw_store), 16'h0001);
      chk(keypad_freq, out_freq);
      chk(16'({ud_enable, ud_freq}), 16'h0050);
      press(5'h01);
      ud_step <= 16'h00c8;
      press(5'h09);
      chk(ud_freq, 16'h0000);
      $display("test up_down done");
      setfn(1, FN_REV);
      setfn(2, 5'h05);
      setfn(3, 5'h05);
      press(5'h1f);
      chk(16'({run_fwd, run_rev}), 16'h0000);
      setfn(0, 5'h05);
      setfn(1, 5'h05);
      for (int j = 0; j < 10; j++) begin
         setfn(4, codes[j]);
         chk(16'(dec), 16'(10'h200 >> j));
      end
      for (int i = 0; i < 8; i++) begin
         setfn(4, i[2] ? FN_SPD_MSB : 5'h05);
         setfn(3, i[1] ? FN_SPD_MID : 5'h05);
         setfn(2, i[0] ? FN_SPD_LSB : 5'h05);
         chk(16'(speed_idx), 16'(i));
      end
      setfn(3, FN_JOG_FWD);
      setfn(4, FN_JOG_REV);
      chk(16'({jog_fwd, jog_rev}), 16'h0000);
      setfn(3, 5'h05);
      setfn(4, 5'h05);
      run_mode <= RUNMODE_3W;
      setfn(0, FN_JOG_FWD);
      chk(16'(jog_fwd), 16'h0000);
      run_mode <= 2'h0;
      setfn(0, FN_JOG_FWD);
      chk(16'(jog_fwd), 16'h0001);
      saw_reset = 1'b0;
      setfn(0, FN_FRESET);
      repeat (4) @(posedge core_clk);
      chk(16'(saw_reset), 16'h0001);
      $display("test decode done");
      @(posedge core_clk);
      polarity_nc <= 5'h01;
      settle(5'h1e);
      $display("test polarity done");
      stop_test();
   end
endmodule : mfi_decoder_test

// ===== mfi_pkg.sv
// Purpose: constants for the multifunction input decoder
// Assumes: 100 MHz core clock, frequencies in 0.01 Hz units
// Notes:   function codes follow the terminal function table
package mfi_pkg;
   localparam int          NUM_TERM      = 5;
   localparam int          FREQ_W        = 16;
   localparam int          CLK_MHZ       = 100;
   localparam int          TICK_US       = 1000;
   localparam int          TICK_CYC      = TICK_US * CLK_MHZ;
   localparam int          HOLD_MS       = 2000;
   localparam logic [4:0]  FN_FWD        = 5'h00;
   localparam logic [4:0]  FN_REV        = 5'h01;
   localparam logic [4:0]  FN_SPD_LSB    = 5'h02;
   localparam logic [4:0]  FN_SPD_MID    = 5'h03;
   localparam logic [4:0]  FN_SPD_MSB    = 5'h04;
   localparam logic [4:0]  FN_JOG_FWD    = 5'h06;
   localparam logic [4:0]  FN_JOG_REV    = 5'h07;
   localparam logic [4:0]  FN_UP         = 5'h08;
   localparam logic [4:0]  FN_DOWN       = 5'h09;
   localparam logic [4:0]  FN_RAMP2      = 5'h0a;
   localparam logic [4:0]  FN_HOLD       = 5'h0b;
   localparam logic [4:0]  FN_RUN_SRC    = 5'h0c;
   localparam logic [4:0]  FN_FREQ_SRC   = 5'h0d;
   localparam logic [4:0]  FN_RSTOP      = 5'h0e;
   localparam logic [4:0]  FN_BBLOCK     = 5'h0f;
   localparam logic [4:0]  FN_PID_OFF    = 5'h10;
   localparam logic [4:0]  FN_FRESET     = 5'h11;
   localparam logic [4:0]  FN_AUTO       = 5'h12;
   localparam logic [1:0]  RUNMODE_3W    = 2'h2;
   localparam logic [1:0]  KEEP_HOLD_OFF = 2'h0;
   localparam logic [1:0]  KEEP_ZERO     = 2'h1;
   localparam logic [1:0]  KEEP_HOLD_ON  = 2'h2;
   localparam logic [15:0] FREQ_RST      = 16'h0000;
   localparam logic [15:0] STEP_MAX      = 16'h01f4;
   typedef enum logic [1:0] {
      UD_IDLE = 2'b00,
      UD_STEP = 2'b01,
      UD_WAIT = 2'b10,
      UD_RPT  = 2'b11
   } mfi_ud_type;
endpackage : mfi_pkg

// ===== mfi_switch_model.sv
// Purpose: switches and push buttons wired to the five input terminals
// Assumes: contacts bounce for a few cycles after every change
// Notes:   glitch makes a short spurious closure on one terminal
`timescale 1ns/1ps
module mfi_switch_model #(
   parameter int BOUNCE = 7
) (
   input  wire logic       core_clk,
   input  wire logic [4:0] want,
   output logic      [4:0] pins
);
   logic [4:0] level_r = 5'h00;
   logic [4:0] diff_r  = 5'h00;
   logic [4:0] glitch_r = 5'h00;
   int         chatter = 0;

   // contacts chatter on changed terminals, then settle
   always @(posedge core_clk) begin
      if (want != level_r) begin
         chatter <= BOUNCE;
         diff_r  <= want ^ level_r;
         level_r <= want;
      end else if (chatter > 0) begin
         chatter <= chatter - 1;
      end
   end
   assign pins = level_r ^ glitch_r ^ (chatter[0] ? diff_r : 5'h00);

   // spurious closure shorter than the filter window
   task automatic glitch(input int idx, input int len);
      @(posedge core_clk);
      glitch_r[idx] <= 1'b1;
      repeat (len) @(posedge core_clk);
      glitch_r[idx] <= 1'b0;
   endtask : glitch
endmodule : mfi_switch_model
